// *** inc/irq_group2_regs.vh ***
// Register indices, reset values and field positions of the group-2 interrupt priority block.
`ifndef IRQ_GROUP2_REGS_VH
`define IRQ_GROUP2_REGS_VH

// Register indices; the byte address on the bus is four times the index.
`define IDX_GROUP1_ENABLE_HIGH 14'h0FC4
`define IDX_GROUP1_ENABLE_LOW 14'h0FC5
`define IDX_GROUP2_ENABLE_HIGH 14'h0FC7
`define IDX_GROUP2_ENABLE_LOW 14'h0FC8
`define IDX_PIN_EDGE_POLARITY 14'h0FCD
`define IDX_PIN_PORT_CHOICE 14'h0FCE
`define IDX_IRQ_CONTROL 14'h0FCF
`define IDX_IRQ_STATUS 14'h0FD0
`define IDX_IRQ_MASK 14'h0FD1

// Reset values.
`define RST_ENABLE 8'h00
`define RST_EDGE 8'h00
`define RST_PORT 8'h00
`define RST_MASTER 1'b0
`define RST_STATUS 16'h0000
`define RST_MASK 16'h0000

// Field positions.
`define MASTER_EN_BIT 7
`define SRC_PIN_LSB 0
`define SRC_GROUP2_LSB 8

// Priority levels.
`define LEVEL_OFF 2'h0
`define LEVEL_LOW 2'h1
`define LEVEL_NOMINAL 2'h2
`define LEVEL_HIGH 2'h3

`endif

// *** rtl/pin_edge_detect.v ***
// Pin synchroniser, port selection and edge detector for the eight shared pin sources.
`timescale 1ns/1ps
module pin_edge_detect (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Pins from outside the clock domain
    input wire [7:0] porta_pin_x,
    input wire [7:0] portd_pin_x,
    // Controls
    input wire [7:0] port_choice_bit,
    input wire [7:0] edge_polarity_bit,
    // One-cycle request per detected edge
    output wire [7:0] pin_evt
);
    reg [7:0] a_meta_ff;
    reg [7:0] a_sync_ff;
    reg [7:0] d_meta_ff;
    reg [7:0] d_sync_ff;
    reg [7:0] prev_ff;
    wire [7:0] sel_pin;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            a_meta_ff <= 8'h00;
            a_sync_ff <= 8'h00;
            d_meta_ff <= 8'h00;
            d_sync_ff <= 8'h00;
            prev_ff <= 8'h00;
        end
        else
        begin
            a_meta_ff <= porta_pin_x;
            a_sync_ff <= a_meta_ff;
            d_meta_ff <= portd_pin_x;
            d_sync_ff <= d_meta_ff;
            prev_ff <= sel_pin;
        end
    end

    // Changing the port choice while the two pins differ looks like an edge to this logic.
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : g_pin
            assign sel_pin[g] = port_choice_bit[g] ? d_sync_ff[g] : a_sync_ff[g];
            assign pin_evt[g] = edge_polarity_bit[g] ? (sel_pin[g] & ~prev_ff[g])
                                                     : (~sel_pin[g] & prev_ff[g]);
        end
    endgenerate
endmodule // pin_edge_detect

// *** rtl/prio_arbiter.v ***
// Picks the pending source with the highest enabled priority level.
`timescale 1ns/1ps
`include "irq_group2_regs.vh"
module prio_arbiter (
    // Pending and enable pairs, one bit per source
    input wire [15:0] pend,
    input wire [15:0] en_hi,
    input wire [15:0] en_lo,
    // Winner
    output reg win_valid,
    output reg [1:0] win_level,
    output reg [3:0] win_idx
);
    integer i;
    reg [1:0] lvl;

    // Scanning downward with >= lets the lowest index win among equal levels.
    always @*
    begin
        win_valid = 1'b0;
        win_level = `LEVEL_OFF;
        win_idx = 4'h0;
        lvl = `LEVEL_OFF;
        for (i = 15; i >= 0; i = i - 1)
        begin
            lvl = {en_hi[i], en_lo[i]};
            if (pend[i] && (lvl != `LEVEL_OFF) && (lvl >= win_level))
            begin
                win_valid = 1'b1;
                win_level = lvl;
                win_idx = i[3:0];
            end
        end
    end
endmodule // prio_arbiter

// *** rtl/irq_group2_priority_and_port_select.v ***
// Group-2 interrupt priority, pin port and edge selection block with an APB register slave.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "irq_group2_regs.vh"
module irq_group2_priority_and_port_select (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Group-2 source events from same-clock peripherals
    input wire timer4_evt,
    input wire uart2_rx_evt,
    input wire uart2_tx_evt,
    input wire dma_evt,
    input wire [3:0] portc_evt,
    // Shared interrupt pins
    input wire [7:0] porta_pin_x,
    input wire [7:0] portd_pin_x,
    // Core request and acknowledge
    output wire core_req,
    output wire [1:0] core_req_level,
    output wire [3:0] core_req_src,
    input wire core_ack,
    // Summary interrupt
    output wire irq_out
);
    reg [7:0] group1_enable_high_ff;
    reg [7:0] group1_enable_low_ff;
    reg [7:0] group2_enable_high_ff;
    reg [7:0] group2_enable_low_ff;
    reg [7:0] pin_edge_polarity_ff;
    reg [7:0] pin_port_choice_ff;
    reg master_irq_enable_ff;
    reg [15:0] status_ff;
    reg [15:0] mask_ff;
    reg [31:0] prdata_ff;
    reg pready_ff;
    reg pslverr_ff;
    reg core_req_ff;
    reg [1:0] core_req_level_ff;
    reg [3:0] core_req_src_ff;
    reg irq_out_ff;

    reg [15:0] nxt_status;
    reg nxt_master;
    reg [31:0] rd_value;
    reg rd_hit;

    wire [13:0] reg_idx;
    wire access;
    wire wr_en;
    wire status_wr;
    wire ctl_wr;
    wire ack_take;
    wire [7:0] pin_evt;
    wire [7:0] group2_evt;
    wire [15:0] all_evt;
    wire [15:0] all_hi;
    wire [15:0] all_lo;
    wire [15:0] ack_clr;
    wire win_valid;
    wire [1:0] win_level;
    wire [3:0] win_idx;

    assign reg_idx = paddr[15:2];
    assign access = psel & penable;
    assign wr_en = access & pready_ff & pwrite;
    // Writes land only in the cycle that pready stands, so each strobe is one cycle long.
    assign status_wr = wr_en & (reg_idx == `IDX_IRQ_STATUS);
    assign ctl_wr = wr_en & (reg_idx == `IDX_IRQ_CONTROL);
    assign ack_take = core_ack & core_req_ff;

    // Group-2 event order matches the enable bit layout.
    assign group2_evt = {timer4_evt, uart2_rx_evt, uart2_tx_evt, dma_evt, portc_evt};

    pin_edge_detect u_pin_edge_detect (
        .pclk(pclk),
        .presetn(presetn),
        .porta_pin_x(porta_pin_x),
        .portd_pin_x(portd_pin_x),
        .port_choice_bit(pin_port_choice_ff),
        .edge_polarity_bit(pin_edge_polarity_ff),
        .pin_evt(pin_evt)
    );

    // Pins sit in the low byte and use the group-1 pairs.
    assign all_evt = {group2_evt, pin_evt};
    assign all_hi = {group2_enable_high_ff, group1_enable_high_ff};
    assign all_lo = {group2_enable_low_ff, group1_enable_low_ff};

    prio_arbiter u_prio_arbiter (
        .pend(status_ff),
        .en_hi(all_hi),
        .en_lo(all_lo),
        .win_valid(win_valid),
        .win_level(win_level),
        .win_idx(win_idx)
    );

    // Acknowledge retires the source that was on offer to the core.
    assign ack_clr = ack_take ? (16'h0001 << core_req_src_ff) : 16'h0000;

    // Status: a new event wins over a clear in the same cycle.
    always @*
    begin
        nxt_status = status_ff & ~ack_clr;
        if (status_wr)
        begin
            nxt_status = nxt_status & ~pwdata[15:0];
        end
        nxt_status = nxt_status | all_evt;
    end

    // Master enable: the acknowledge clear wins over a software set.
    always @*
    begin
        nxt_master = master_irq_enable_ff;
        if (ctl_wr)
        begin
            nxt_master = pwdata[`MASTER_EN_BIT];
        end
        if (ack_take)
        begin
            nxt_master = 1'b0;
        end
    end

    // Read mux; unused upper bits read as zero.
    always @*
    begin
        rd_value = 32'h00000000;
        rd_hit = 1'b1;
        case (reg_idx)
            `IDX_GROUP1_ENABLE_HIGH:
            begin
                rd_value[7:0] = group1_enable_high_ff;
            end
            `IDX_GROUP1_ENABLE_LOW:
            begin
                rd_value[7:0] = group1_enable_low_ff;
            end
            `IDX_GROUP2_ENABLE_HIGH:
            begin
                rd_value[7:0] = group2_enable_high_ff;
            end
            `IDX_GROUP2_ENABLE_LOW:
            begin
                rd_value[7:0] = group2_enable_low_ff;
            end
            `IDX_PIN_EDGE_POLARITY:
            begin
                rd_value[7:0] = pin_edge_polarity_ff;
            end
            `IDX_PIN_PORT_CHOICE:
            begin
                rd_value[7:0] = pin_port_choice_ff;
            end
            `IDX_IRQ_CONTROL:
            begin
                rd_value[`MASTER_EN_BIT] = master_irq_enable_ff;
            end
            `IDX_IRQ_STATUS:
            begin
                rd_value[15:0] = status_ff;
            end
            `IDX_IRQ_MASK:
            begin
                rd_value[15:0] = mask_ff;
            end
            default:
            begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // Bus handshake: one wait cycle, so every access completes in its second access cycle.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            if (access && !pready_ff)
            begin
                pready_ff <= 1'b1;
                pslverr_ff <= ~rd_hit;
                prdata_ff <= pwrite ? 32'h00000000 : rd_value;
            end
            else
            begin
                pready_ff <= 1'b0;
                pslverr_ff <= 1'b0;
                prdata_ff <= 32'h00000000;
            end
        end
    end

    // Software-written configuration.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            group1_enable_high_ff <= `RST_ENABLE;
            group1_enable_low_ff <= `RST_ENABLE;
            group2_enable_high_ff <= `RST_ENABLE;
            group2_enable_low_ff <= `RST_ENABLE;
            pin_edge_polarity_ff <= `RST_EDGE;
            pin_port_choice_ff <= `RST_PORT;
            mask_ff <= `RST_MASK;
        end
        else if (wr_en)
        begin
            case (reg_idx)
                `IDX_GROUP1_ENABLE_HIGH:
                begin
                    group1_enable_high_ff <= pwdata[7:0];
                end
                `IDX_GROUP1_ENABLE_LOW:
                begin
                    group1_enable_low_ff <= pwdata[7:0];
                end
                `IDX_GROUP2_ENABLE_HIGH:
                begin
                    group2_enable_high_ff <= pwdata[7:0];
                end
                `IDX_GROUP2_ENABLE_LOW:
                begin
                    group2_enable_low_ff <= pwdata[7:0];
                end
                `IDX_PIN_EDGE_POLARITY:
                begin
                    pin_edge_polarity_ff <= pwdata[7:0];
                end
                `IDX_PIN_PORT_CHOICE:
                begin
                    pin_port_choice_ff <= pwdata[7:0];
                end
                `IDX_IRQ_MASK:
                begin
                    mask_ff <= pwdata[15:0];
                end
                default:
                begin
                    mask_ff <= mask_ff;
                end
            endcase
        end
    end

    // Pending state and master enable.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_ff <= `RST_STATUS;
            master_irq_enable_ff <= `RST_MASTER;
        end
        else
        begin
            status_ff <= nxt_status;
            master_irq_enable_ff <= nxt_master;
        end
    end

    // Registered request to the core and the summary interrupt.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            core_req_ff <= 1'b0;
            core_req_level_ff <= `LEVEL_OFF;
            core_req_src_ff <= 4'h0;
            irq_out_ff <= 1'b0;
        end
        else
        begin
            // The request drops the cycle after an acknowledge, since master enable clears.
            core_req_ff <= win_valid & nxt_master & ~(|(ack_clr & (16'h0001 << win_idx)));
            core_req_level_ff <= win_level;
            core_req_src_ff <= win_idx;
            // Taking the next status lets irq_out rise together with the status bit.
            irq_out_ff <= |(nxt_status & mask_ff);
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign core_req = core_req_ff;
    assign core_req_level = core_req_level_ff;
    assign core_req_src = core_req_src_ff;
    assign irq_out = irq_out_ff;
endmodule // irq_group2_priority_and_port_select

// *** tb/irq_group2_props.sv ***
// Port checks for the group-2 interrupt block.
`timescale 1ns/1ps
module irq_group2_props (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Register bus
    input wire psel,
    input wire penable,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Core side
    input wire core_req,
    input wire [1:0] core_req_level,
    input wire core_ack,
    input wire irq_out
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence answer_s;
        !pready ##1 pready;
    endsequence
    chk_one_wait: assert property (setup_s |=> answer_s)
        else $error("bus answer late");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    chk_req_level: assert property (core_req |-> core_req_level != 2'h0)
        else $error("request at disabled level");
    chk_ack_drop: assert property (core_req && core_ack |=> !core_req [*2])
        else $error("request after acknowledge");
    // A write lands one edge before the request reacts, so two idle bus cycles are needed.
    chk_req_hold: assert property (core_req && !core_ack && !psel && !$past(psel) |=> core_req)
        else $error("request dropped");
    chk_reset_quiet: assert property ($rose(presetn) |-> !core_req && !irq_out)
        else $error("output active after reset");
endmodule // irq_group2_props

bind irq_group2_priority_and_port_select irq_group2_props chk_u (.*);

// *** tb/core_model.sv ***
// Behavioural core that acknowledges requests, promptly or after a stall.
`timescale 1ns/1ps
module core_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Request from the block and permission from the bench
    input wire logic core_req,
    input wire logic ack_on,
    // Acknowledge pulse
    output logic core_ack
);
    logic [1:0] cnt_ff;
    logic [1:0] dly_ff;
    // The stall grows by one on each answer and wraps from 3 back to 0, so prompt and slow answers both occur.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_ff <= 2'h0;
            dly_ff <= 2'h0;
            core_ack <= 1'b0;
        end
        else
        begin
            core_ack <= 1'b0;
            if (ack_on && core_req && !core_ack)
            begin
                cnt_ff <= cnt_ff + 2'h1;
                if (cnt_ff == dly_ff)
                begin
                    core_ack <= 1'b1;
                    cnt_ff <= 2'h0;
                    dly_ff <= dly_ff + 2'h1;
                end
            end
        end
    end
endmodule // core_model

// *** tb/irq_group2_priority_and_port_select_tb_top.sv ***
// Self-checking bench for the group-2 interrupt priority block.
`timescale 1ns/1ps
`include "irq_group2_regs.vh"
module irq_group2_priority_and_port_select_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic ack_on = 1'b0;
    logic err;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] rd;
    logic [7:0] ev = 8'h00;
    logic [7:0] porta_pin_x = 8'h00;
    logic [7:0] portd_pin_x = 8'h00;
    logic [7:0] h, l, e, es, ps;
    logic [6:0] x;
    logic [13:0] regs [4] = '{`IDX_GROUP2_ENABLE_HIGH, `IDX_GROUP2_ENABLE_LOW,
        `IDX_PIN_EDGE_POLARITY, `IDX_PIN_PORT_CHOICE};
    wire [31:0] prdata;
    wire pready, pslverr, core_req, core_ack, irq_out;
    wire [1:0] core_req_level;
    wire [3:0] core_req_src;
    integer seed = 32'h2EA1;
    int failures = 0;
    int n_tests = 0;
    irq_group2_priority_and_port_select dut_u (.*, .timer4_evt(ev[7]), .uart2_rx_evt(ev[6]),
        .uart2_tx_evt(ev[5]), .dma_evt(ev[4]), .portc_evt(ev[3:0]));
    core_model core_u (.*);
    initial
    begin
        forever #2 pclk = ~pclk;
    end
    task automatic final_report;
        $display("Comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic to_out;
        failures++;
        $display("ERROR wait expected done seen timeout");
        final_report();
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [13:0] idx, input logic [31:0] wd);
        int t;
        t = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        rd = prdata;
        err = pslverr;
        if (t >= 20)
            to_out();
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge keeps the next call from driving psel twice in one step.
        @(posedge pclk);
    endtask
    // Status is cleared first so that stray edges from earlier set-up do not leak in.
    task automatic arm(input logic [7:0] ctl, input logic [7:0] mk);
        apb(1'b1, `IDX_IRQ_STATUS, 32'h0000FFFF);
        apb(1'b1, `IDX_IRQ_MASK, {16'h0, mk, 8'h00});
        apb(1'b1, `IDX_IRQ_CONTROL, {24'h0, ctl});
        chk("irq cleared", irq_out, 1'b0);
    endtask
    task automatic take;
        int t;
        t = 0;
        if (core_req === 1'b1)
        begin
            ack_on <= 1'b1;
            while (core_req === 1'b1 && t < 20)
            begin
                @(posedge pclk);
                t++;
            end
            ack_on <= 1'b0;
            if (t >= 20)
                to_out();
            apb(1'b0, `IDX_IRQ_CONTROL, 32'h0);
            chk("master after ack", rd, 32'h0);
        end
    endtask
    function automatic logic [6:0] best(input logic [7:0] hi, input logic [7:0] lo,
        input logic [7:0] ep);
        logic [6:0] r;
        r = 7'h00;
        for (int j = 7; j >= 0; j--)
            if (ep[j] && {hi[j], lo[j]} != 2'h0 && {hi[j], lo[j]} >= r[5:4])
                r = {1'b1, hi[j], lo[j], 4'(8 + j)};
        return r;
    endfunction
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int j = 0; j < 4; j++)
        begin
            apb(1'b0, regs[j], 32'h0);
            chk("reset value", rd, 32'h0);
            h = 8'($random(seed));
            apb(1'b1, regs[j], {24'hA5A5A5, h});
            apb(1'b0, regs[j], 32'h0);
            chk("read back", rd, {24'h0, h});
        end
        apb(1'b0, 14'h0FC6, 32'h0);
        chk("unmapped error", err, 1'b1);
        chk("unmapped data", rd, 32'h0);
        for (int i = 0; i < 20; i++)
        begin
            e = (i < 8) ? 8'(8'h01 << i) : 8'($random(seed));
            h = (i < 8) ? {8{i[1]}} : 8'($random(seed));
            l = (i < 8) ? {8{i[0]}} : 8'($random(seed));
            apb(1'b1, `IDX_GROUP2_ENABLE_HIGH, {24'h0, h});
            apb(1'b1, `IDX_GROUP2_ENABLE_LOW, {24'h0, l});
            arm((i == 19) ? 8'h00 : 8'h80, h);
            ev <= e;
            @(posedge pclk);
            ev <= 8'h00;
            cyc(3);
            x = best(h, l, e);
            chk("irq_out", irq_out, |(h & e));
            chk("core_req", core_req, x[6] && i != 19);
            if (core_req === 1'b1)
            begin
                chk("level", core_req_level, x[5:4]);
                chk("source", core_req_src, x[3:0]);
            end
            take();
        end
        for (int k = 0; k < 8; k++)
        begin
            es = 8'($random(seed));
            ps = 8'($random(seed));
            l = 8'($random(seed));
            porta_pin_x <= ~es;
            portd_pin_x <= ~es;
            apb(1'b1, `IDX_GROUP1_ENABLE_HIGH, 32'hFF);
            apb(1'b1, `IDX_GROUP1_ENABLE_LOW, {24'h0, l});
            apb(1'b1, `IDX_PIN_EDGE_POLARITY, {24'h0, es});
            apb(1'b1, `IDX_PIN_PORT_CHOICE, {24'h0, ps});
            cyc(4);
            arm(8'h80, 8'h00);
            if (ps[k])
                porta_pin_x[k] <= es[k];
            else
                portd_pin_x[k] <= es[k];
            cyc(6);
            chk("other port", core_req, 1'b0);
            if (ps[k])
                portd_pin_x[k] <= es[k];
            else
                porta_pin_x[k] <= es[k];
            cyc(2);
            porta_pin_x <= ~es;
            portd_pin_x <= ~es;
            cyc(6);
            chk("pin request", core_req, 1'b1);
            chk("pin source", core_req_src, k);
            chk("pin level", core_req_level, {1'b1, l[k]});
            take();
            apb(1'b1, `IDX_IRQ_CONTROL, 32'h80);
            cyc(2);
            chk("single request", core_req, 1'b0);
        end
        final_report();
    end
endmodule // irq_group2_priority_and_port_select_tb_top
